/* pkg/fsw_pkg.sv */
// constants shared by the flash word-program host controller
package fsw_pkg;
  localparam int CLK_NS = 50;
  localparam int T_PULSE_NS = 100;
  localparam int T_RECOVER_NS = 50;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int POLL_LIMIT_DEF = 100000;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_PROG_SUSP = 2;
  localparam int SR_LOCK_VIOL = 1;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_FLASH_STATUS = 8'h10;
  localparam int CTRL_GO_PROGRAM = 0;
  localparam int CTRL_GO_CLEAR = 1;
  localparam int CTRL_ALT_SETUP = 2;
  localparam int CTRL_GO_STATUS = 3;
  localparam int CTRL_ACK_DONE = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_TIMEOUT = 2;
  localparam int STAT_ERROR = 3;
  localparam logic [7:0] RESET_FLASH_STATUS = 8'h80;
endpackage : fsw_pkg

/* rtl/fsw_bus_cycle.sv */
// one asynchronous flash bus cycle: write or read, with input synchroniser
`timescale 1ns/1ps
module fsw_bus_cycle (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic is_read,
  input wire logic [fsw_pkg::ADDR_W-1:0] cyc_addr,
  input wire logic [fsw_pkg::DATA_W-1:0] cyc_wdata,
  output logic busy,
  output logic done,
  output logic [fsw_pkg::DATA_W-1:0] rdata,
  output logic [fsw_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [fsw_pkg::DATA_W-1:0] dq_in,
  output logic [fsw_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_SETUP = 4'b0010,
    P_ACTIVE = 4'b0100,
    P_RECOVER = 4'b1000
  } fsw_phase_t;

  localparam logic [3:0] WR_LAST = 4'(fsw_pkg::PULSE_CYC - 1);
  localparam logic [3:0] RD_LAST = 4'(fsw_pkg::PULSE_CYC + fsw_pkg::SYNC_CYC - 1);
  localparam logic [3:0] REC_LAST = 4'(fsw_pkg::RECOVER_CYC - 1);

  fsw_phase_t phase;
  logic [3:0] cnt;
  logic rd_mode;
  logic [fsw_pkg::DATA_W-1:0] s1, s2, s3, dq_filt;
  wire active_end = (phase == P_ACTIVE) && (cnt == (rd_mode ? RD_LAST : WR_LAST));
  wire recover_end = (phase == P_RECOVER) && (cnt == REC_LAST);

  assign busy = (phase != P_IDLE);

  // three-stage sampler; a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    s1 <= dq_in;
    s2 <= s1;
    s3 <= s2;
    if (reset) begin
      dq_filt <= '0;
    end else if (s2 == s3) begin
      dq_filt <= s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      phase <= P_IDLE;
      cnt <= '0;
      rd_mode <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (phase)
        P_IDLE: begin
          if (start) begin
            // chip enable first, so the strobe falls last
            phase <= P_SETUP;
            rd_mode <= is_read;
            flash_addr <= cyc_addr;
            flash_ce_n <= 1'b0;
            dq_out <= cyc_wdata;
            dq_oe <= !is_read;
          end
        end
        P_SETUP: begin
          phase <= P_ACTIVE;
          cnt <= '0;
          flash_oe_n <= !rd_mode;
          flash_we_n <= rd_mode;
        end
        P_ACTIVE: begin
          cnt <= cnt + 4'h1;
          if (active_end) begin
            phase <= P_RECOVER;
            cnt <= '0;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            if (rd_mode) begin
              rdata <= dq_filt;
            end
          end
        end
        P_RECOVER: begin
          cnt <= cnt + 4'h1;
          flash_ce_n <= 1'b1;
          dq_oe <= 1'b0;
          if (recover_end) begin
            phase <= P_IDLE;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_oe_toggles_high: assert property ($fell(flash_oe_n) |-> ##[2:8] flash_oe_n)
    else $error("read strobe not released between status reads");
  a_oe_falls_last: assert property ($fell(flash_oe_n) |-> !flash_ce_n && $past(!flash_ce_n))
    else $error("read strobe fell before chip enable");
  a_we_pulse_width: assert property ($fell(flash_we_n) |-> !flash_we_n ##1 !flash_we_n ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_no_drive_reading: assert property (!flash_oe_n |-> !dq_oe)
    else $error("host drives data while device outputs");
endmodule : fsw_bus_cycle

/* rtl/fsw_host.sv */
// host controller: programs one flash word and checks its status
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module fsw_host #(
  parameter int POLL_LIMIT = fsw_pkg::POLL_LIMIT_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [fsw_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [fsw_pkg::DATA_W-1:0] dq_in,
  output logic [fsw_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SETUP = 7'b0000010,
    S_DATA = 7'b0000100,
    S_RSCMD = 7'b0001000,
    S_POLL = 7'b0010000,
    S_CLEAR = 7'b0100000,
    S_ARRAY = 7'b1000000
  } fsw_state_t;

  localparam logic [19:0] POLL_LAST = 20'(POLL_LIMIT - 1);

  fsw_state_t state, next_state;
  logic issued;
  logic [fsw_pkg::ADDR_W-1:0] word_addr;
  logic [fsw_pkg::DATA_W-1:0] word_data;
  logic alt_setup;
  logic [7:0] flash_status;
  logic done_flag, timeout_flag, error_flag;
  logic [19:0] poll_cnt;
  logic cyc_busy, cyc_done;
  logic [fsw_pkg::DATA_W-1:0] cyc_rdata;

  function automatic logic [fsw_pkg::DATA_W-1:0] fsw_cmd(input logic [7:0] code);
    return {8'h00, code};
  endfunction : fsw_cmd

  // decode of the register port
  wire wr_ctrl = reg_write && (reg_addr == fsw_pkg::REG_CTRL);
  wire wr_addr = reg_write && (reg_addr == fsw_pkg::REG_ADDR);
  wire wr_data = reg_write && (reg_addr == fsw_pkg::REG_DATA);
  wire idle = (state == S_IDLE);
  wire go_program = wr_ctrl && reg_wdata[fsw_pkg::CTRL_GO_PROGRAM] && idle;
  wire go_clear = wr_ctrl && reg_wdata[fsw_pkg::CTRL_GO_CLEAR] && idle;
  wire go_status = wr_ctrl && reg_wdata[fsw_pkg::CTRL_GO_STATUS] && idle;
  wire ack_done = wr_ctrl && reg_wdata[fsw_pkg::CTRL_ACK_DONE];

  // judging the answer of one status poll
  wire [7:0] poll_sr = cyc_rdata[7:0];
  wire poll_ready = poll_sr[fsw_pkg::SR_READY];
  wire poll_err = poll_sr[fsw_pkg::SR_LOCK_VIOL] || poll_sr[fsw_pkg::SR_SUPPLY_LOW]
                  || poll_sr[fsw_pkg::SR_PROG_ERR] || poll_sr[fsw_pkg::SR_ERASE_ERR];
  wire poll_end = (state == S_POLL) && cyc_done;
  wire poll_expired = (poll_cnt == POLL_LAST);
  wire seq_end = cyc_done && ((state == S_ARRAY) || (state == S_CLEAR));

  // what each state puts on the flash bus
  wire cyc_start = !idle && !issued && !cyc_busy;
  wire cyc_is_read = (state == S_POLL);
  wire [fsw_pkg::DATA_W-1:0] setup_word = fsw_cmd(alt_setup ? fsw_pkg::CMD_PROG_ALT : fsw_pkg::CMD_PROG_SETUP);
  wire [fsw_pkg::DATA_W-1:0] cyc_wdata =
    (state == S_SETUP) ? setup_word :
    (state == S_DATA) ? word_data :
    (state == S_RSCMD) ? fsw_cmd(fsw_pkg::CMD_READ_STATUS) :
    (state == S_CLEAR) ? fsw_cmd(fsw_pkg::CMD_CLEAR_STATUS) :
    fsw_cmd(fsw_pkg::CMD_READ_ARRAY);

  fsw_bus_cycle u_cycle (
    .mclk(mclk),
    .reset(reset),
    .start(cyc_start),
    .is_read(cyc_is_read),
    .cyc_addr(word_addr),
    .cyc_wdata(cyc_wdata),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (go_program) next_state = S_SETUP;
        else if (go_status) next_state = S_RSCMD;
        else if (go_clear) next_state = S_CLEAR;
      end
      S_SETUP: if (cyc_done) next_state = S_DATA;
      S_DATA: if (cyc_done) next_state = S_POLL;
      S_RSCMD: if (cyc_done) next_state = S_POLL;
      S_POLL: begin
        if (poll_end && poll_ready) begin
          // clearing also covers supply low before next program
          next_state = poll_err ? S_CLEAR : S_ARRAY;
        end else if (poll_end && poll_expired) begin
          next_state = S_ARRAY;
        end
      end
      S_CLEAR: if (cyc_done) next_state = S_IDLE;
      S_ARRAY: if (cyc_done) next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= S_IDLE;
      issued <= 1'b0;
      poll_cnt <= '0;
    end else begin
      state <= next_state;
      issued <= cyc_done ? 1'b0 : (issued || cyc_start);
      poll_cnt <= (state != S_POLL) ? 20'h00000 : (poll_end ? poll_cnt + 20'h00001 : poll_cnt);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      word_addr <= '0;
      word_data <= '0;
      alt_setup <= 1'b0;
      flash_status <= fsw_pkg::RESET_FLASH_STATUS;
    end else begin
      if (wr_addr && idle) word_addr <= reg_wdata[fsw_pkg::ADDR_W-1:0];
      if (wr_data && idle) word_data <= reg_wdata[fsw_pkg::DATA_W-1:0];
      if (wr_ctrl && idle) alt_setup <= reg_wdata[fsw_pkg::CTRL_ALT_SETUP];
      // every poll is a fresh read of the device status
      if (poll_end) flash_status <= poll_sr;
    end
  end

  // sticky flags: done setting wins over its acknowledge; timeout and error clear only on a new program or status start
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_flag <= 1'b0;
      timeout_flag <= 1'b0;
      error_flag <= 1'b0;
    end else begin
      done_flag <= seq_end || (done_flag && !ack_done);
      if (go_program || go_status) begin
        timeout_flag <= 1'b0;
        error_flag <= 1'b0;
      end else begin
        if (poll_end && !poll_ready && poll_expired) timeout_flag <= 1'b1;
        if (poll_end && poll_ready && poll_err) error_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        fsw_pkg::REG_CTRL: reg_rdata <= {29'h0, alt_setup, 2'h0};
        fsw_pkg::REG_ADDR: reg_rdata <= {11'h000, word_addr};
        fsw_pkg::REG_DATA: reg_rdata <= {16'h0000, word_data};
        fsw_pkg::REG_STAT: reg_rdata <= {28'h0, error_flag, timeout_flag, done_flag, !idle};
        fsw_pkg::REG_FLASH_STATUS: reg_rdata <= {24'h0, flash_status};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_data_after_setup: assert property (state == S_SETUP && cyc_done |=> state == S_DATA ##[1:6] dq_oe)
    else $error("data write does not follow setup write");
  a_ready_before_judge: assert property ($rose(error_flag) |-> $past(poll_end) && $past(poll_ready))
    else $error("error judged while device busy");
  a_busy_keeps_polling: assert property (poll_end && !poll_ready && !poll_expired |=> state == S_POLL)
    else $error("stopped polling while device busy");
  a_array_after_word: assert property (poll_end && poll_ready && !poll_err |=> state == S_ARRAY)
    else $error("read-array command not issued after word");
  a_supply_low_cleared: assert property (poll_end && poll_ready && poll_sr[fsw_pkg::SR_SUPPLY_LOW]
                                         |=> state == S_CLEAR)
    else $error("supply low not cleared before next operation");
  a_check_each_word: assert property ($rose(done_flag) |-> $past(state) inside {S_ARRAY, S_CLEAR})
    else $error("sequence ended without status check");
  a_status_read_poll: assert property (state == S_RSCMD && cyc_done |=> state == S_POLL ##[1:4] !flash_oe_n)
    else $error("no read cycle after read-status command");
  a_fresh_status: assert property (poll_end |=> flash_status == $past(poll_sr))
    else $error("status copy not refreshed by poll");
  a_poll_strobe_toggle: assert property (poll_end && !poll_ready && !poll_expired |=> ##[1:4] $fell(flash_oe_n))
    else $error("busy poll not followed by a fresh read strobe");

  c_program_ok: cover property (state == S_ARRAY && cyc_done && $past(state) == S_ARRAY);
  c_program_error: cover property (poll_end && poll_ready && poll_err);
  c_busy_poll: cover property (poll_end && !poll_ready);
  c_clear_only: cover property (go_clear);
endmodule : fsw_host

/* sim/fsw_flash_model.sv */
// behavioural flash device: status register and word program flow
`timescale 1ns/1ps
module fsw_flash_model (
  input wire logic [fsw_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  output logic [fsw_pkg::DATA_W-1:0] dq_in,
  input wire logic [fsw_pkg::DATA_W-1:0] dq_out
);
  logic [7:0] sr = 8'h80;
  logic [7:0] inject = 8'h00;
  logic [7:0] pend = 8'h00;
  logic [15:0] dout = 16'h0000;
  logic [15:0] wlog[$];
  logic [fsw_pkg::ADDR_W-1:0] alog[$];
  logic status_mode = 1'b0;
  logic prog_wait = 1'b0;
  // variant that programs at zero supply
  logic zero_supply = 1'b0;
  int busy_reads = 2;
  int busy_left = 0;
  int reads = 0;
  // undriven bus shows the inverse of the last value
  assign dq_in = (!flash_ce_n && !flash_oe_n) ? dout : ~dout;
  always @(posedge flash_we_n) begin
    if (flash_ce_n === 1'b0) begin
      wlog.push_back(dq_out);
      alog.push_back(flash_addr);
      if (prog_wait) begin
        prog_wait = 1'b0;
        sr[7] = 1'b0;
        busy_left = busy_reads;
        pend = zero_supply ? (inject & 8'hF7) : inject;
      end else if (dq_out[7:0] == 8'h40 || dq_out[7:0] == 8'h10) begin
        prog_wait = 1'b1;
        status_mode = 1'b1;
      end else if (dq_out[7:0] == 8'h70) begin
        status_mode = 1'b1;
      end else if (dq_out[7:0] == 8'h50) begin
        sr = sr & 8'hC5;
        status_mode = 1'b0;
      end else if (dq_out[7:0] == 8'hFF) begin
        status_mode = 1'b0;
      end
    end
  end
  always @(negedge flash_oe_n) begin
    if (flash_ce_n === 1'b0) begin
      if (status_mode) begin
        reads++;
        if (busy_left > 0) begin
          busy_left--;
        end else if (!sr[7]) begin
          sr = sr | pend | 8'h80;
        end
        dout = {8'h00, sr & 8'hFE};
      end else begin
        dout = ~dout;
      end
    end
  end
endmodule : fsw_flash_model

/* sim/testbench.sv */
// self-checking bench for the flash word-program host controller
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [fsw_pkg::ADDR_W-1:0] flash_addr;
  logic flash_ce_n;
  logic flash_oe_n;
  logic flash_we_n;
  logic [fsw_pkg::DATA_W-1:0] dq_in;
  logic [fsw_pkg::DATA_W-1:0] dq_out;
  logic dq_oe;
  int failures = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  fsw_host #(.POLL_LIMIT(4)) dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  fsw_flash_model mdl (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .dq_in(dq_in), .dq_out(dq_out));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic run_op(input logic [31:0] ctrl, output logic [31:0] st);
    int n;
    mdl.wlog.delete();
    mdl.alog.delete();
    mdl.reads = 0;
    wr(fsw_pkg::REG_CTRL, ctrl);
    st = 32'h00000001;
    n = 0;
    while (st[fsw_pkg::STAT_BUSY] !== 1'b0 && n < 300) begin
      rd(fsw_pkg::REG_STAT, st);
      n++;
    end
    if (n == 300) chk("operation end", 32'h0, 32'h1);
  endtask : run_op
  task automatic t_reset;
    logic [31:0] v;
    rd(fsw_pkg::REG_STAT, v);
    chk("stat", 32'h0, v);
    rd(fsw_pkg::REG_FLASH_STATUS, v);
    chk("flash status", 32'h80, v);
    rd(8'h14, v);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
  endtask : t_reset
  task automatic t_program(input logic alt, input logic [7:0] fault, input logic [20:0] a, input logic [15:0] d);
    logic [31:0] st;
    mdl.inject = fault;
    wr(fsw_pkg::REG_ADDR, {11'h000, a});
    wr(fsw_pkg::REG_DATA, {16'h0000, d});
    run_op({29'h0, alt, 2'b01}, st);
    chk("stat", (fault != 8'h00) ? 32'hA : 32'h2, st);
    chk("writes", 32'h3, mdl.wlog.size());
    chk("setup", alt ? 32'h10 : 32'h40, mdl.wlog[0]);
    chk("data", d, mdl.wlog[1]);
    chk("setup addr", a, mdl.alog[0]);
    chk("data addr", a, mdl.alog[1]);
    chk("closing", (fault != 8'h00) ? 32'h50 : 32'hFF, mdl.wlog[2]);
    chk("polls", 32'h3, mdl.reads);
    rd(fsw_pkg::REG_FLASH_STATUS, st);
    chk("flash status", {24'h0, 8'h80 | fault}, st);
    rd(fsw_pkg::REG_CTRL, st);
    chk("ctrl", {29'h0, alt, 2'b00}, st);
    rd(fsw_pkg::REG_ADDR, st);
    chk("addr reg", {11'h000, a}, st);
    rd(fsw_pkg::REG_DATA, st);
    chk("data reg", {16'h0000, d}, st);
    wr(fsw_pkg::REG_CTRL, 32'h10);
    $display("test program fault %h done", fault);
  endtask : t_program
  task automatic t_zero_supply;
    logic [31:0] st;
    mdl.zero_supply = 1'b1;
    mdl.inject = 8'h08;
    wr(fsw_pkg::REG_ADDR, 32'h00001234);
    wr(fsw_pkg::REG_DATA, 32'h0000C3C3);
    run_op(32'h1, st);
    chk("stat", 32'h2, st);
    chk("closing", 32'hFF, mdl.wlog[2]);
    rd(fsw_pkg::REG_FLASH_STATUS, st);
    chk("flash status", 32'h80, st);
    wr(fsw_pkg::REG_CTRL, 32'h10);
    mdl.zero_supply = 1'b0;
    mdl.inject = 8'h00;
    $display("test zero supply done");
  endtask : t_zero_supply
  task automatic t_cmds;
    logic [31:0] st;
    mdl.sr = 8'hFD;
    run_op(32'h2, st);
    chk("clear writes", 32'h1, mdl.wlog.size());
    chk("clear cmd", 32'h50, mdl.wlog[0]);
    wr(fsw_pkg::REG_CTRL, 32'h10);
    run_op(32'h8, st);
    chk("stat", 32'h2, st);
    chk("status cmd", 32'h70, mdl.wlog[0]);
    chk("status end", 32'hFF, mdl.wlog[1]);
    rd(fsw_pkg::REG_FLASH_STATUS, st);
    chk("flash status", 32'hC4, st);
    wr(fsw_pkg::REG_CTRL, 32'h10);
    mdl.sr = 8'h80;
    $display("test commands done");
  endtask : t_cmds
  task automatic t_timeout;
    logic [31:0] st;
    mdl.inject = 8'h00;
    mdl.busy_reads = 100;
    run_op(32'h1, st);
    chk("timeout", 32'h1, st[fsw_pkg::STAT_TIMEOUT]);
    chk("polls", 32'h4, mdl.reads);
    chk("closing", 32'hFF, mdl.wlog[mdl.wlog.size() - 1]);
    $display("test timeout done");
  endtask : t_timeout
  task automatic close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_program(1'b0, 8'h00, 21'h1ABCD, 16'h5A5A);
    t_program(1'b1, 8'h10, 21'h00010, 16'hA5C3);
    t_program(1'b0, 8'h00, 21'h1FFFF, 16'hFFFF);
    t_program(1'b0, 8'h02, 21'h00000, 16'h0001);
    t_program(1'b1, 8'h08, 21'h10000, 16'h8000);
    t_cmds;
    t_zero_supply;
    t_timeout;
    close_out;
  end
  initial begin
    #2000000;
    failures++;
    close_out;
  end
endmodule : testbench
